// ---- inc/bod_regs.vh ----
`ifndef BOD_REGS_VH
`define BOD_REGS_VH
// Register byte offsets
`define BOD_CTRL_OFS      12'h000
`define BOD_STAT_OFS      12'h004
`define BOD_PC_OFS        12'h008
`define BOD_FADDR_OFS     12'h00C
`define BOD_FDATA_OFS     12'h010
`define BOD_INSTR_OFS     12'h014
`define BOD_COUNT_OFS     12'h018
// Control fields
`define BOD_CTRL_RUN      0
`define BOD_CTRL_STEP     1
// Status fields
`define BOD_STAT_W_HI     7
`define BOD_STAT_C        8
`define BOD_STAT_DC       9
`define BOD_STAT_Z        10
`define BOD_STAT_SKIP     11
`define BOD_STAT_UNSUP    12
// Reset values
`define BOD_PC_RST        13'h0000
`define BOD_W_RST         8'h00
`define BOD_INSTR_RST     14'h0000
// Instruction word fields
`define BOD_CLASS_HI      13
`define BOD_CLASS_LO      12
`define BOD_OP_HI         11
`define BOD_OP_LO         8
`define BOD_DEST_BIT      7
`define BOD_FILE_HI       6
`define BOD_BIT_HI        9
`define BOD_BIT_LO        7
`define BOD_CLASS_BYTE    2'h0
// Byte-oriented operation nibbles
`define BOD_OP_MISC       4'h0
`define BOD_OP_CLR        4'h1
`define BOD_OP_SUB        4'h2
`define BOD_OP_OR         4'h4
`define BOD_OP_AND        4'h5
`define BOD_OP_XOR        4'h6
`define BOD_OP_ADD        4'h7
`define BOD_OP_MOV        4'h8
`define BOD_OP_INC        4'hA
`define BOD_OP_DECSZ      4'hB
`define BOD_OP_RRC        4'hC
`define BOD_OP_RLC        4'hD
`define BOD_OP_SWAP       4'hE
`define BOD_OP_INCSZ      4'hF
// Timing: last phase of the four-period instruction cycle, then the phase codes
`define BOD_PHASES        2'h3
`define BOD_PH_FETCH      2'h0
`define BOD_PH_READ       2'h1
`define BOD_PH_EXEC       2'h2
`define BOD_PH_WRITE      2'h3
`endif

// ---- hdl/bod_alu.v ----
`timescale 1ns/1ns
`default_nettype none
`include "bod_regs.vh"
module bod_alu (
  // Operation
  input  wire [3:0] op_i,
  input  wire       dest_i,
  // Operands
  input  wire [7:0] fval_i,
  input  wire [7:0] wval_i,
  input  wire       c_i,
  // Result and flags
  output reg  [7:0] res_o,
  output reg        has_res_o,
  output reg        c_o,
  output reg        dc_o,
  output reg        upd_c_o,
  output reg        upd_dc_o,
  output reg        upd_z_o,
  output reg        skip_o,
  output reg        known_o
);
  reg [9:0] sum;

  // Sum with digit carry and carry: {dc, c, sum}
  function [9:0] add9;
    input [7:0] a;
    input [7:0] b;
    input       ci;
    reg   [8:0] s;
    reg   [4:0] l;
    begin
      s = {1'b0, a} + {1'b0, b} + {8'h00, ci};
      l = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
      add9 = {l[4], s};
    end
  endfunction

  always @*
  begin
    sum = 10'h000;
    res_o = fval_i;
    has_res_o = 1'b1;
    c_o = c_i;
    dc_o = 1'b0;
    upd_c_o = 1'b0;
    upd_dc_o = 1'b0;
    upd_z_o = 1'b0;
    skip_o = 1'b0;
    known_o = 1'b1;
    case (op_i)
      `BOD_OP_MISC:
      begin
        res_o = wval_i;
        has_res_o = dest_i;
      end
      `BOD_OP_CLR:
      begin
        res_o = 8'h00;
        upd_z_o = 1'b1;
      end
      `BOD_OP_ADD, `BOD_OP_SUB:
      begin
        if (op_i == `BOD_OP_ADD)
          sum = add9(fval_i, wval_i, 1'b0);
        else
          sum = add9(fval_i, ~wval_i, 1'b1);
        res_o = sum[7:0];
        c_o = sum[8];
        dc_o = sum[9];
        upd_c_o = 1'b1;
        upd_dc_o = 1'b1;
        upd_z_o = 1'b1;
      end
      `BOD_OP_OR:
      begin
        res_o = wval_i | fval_i;
        upd_z_o = 1'b1;
      end
      `BOD_OP_AND:
      begin
        res_o = wval_i & fval_i;
        upd_z_o = 1'b1;
      end
      `BOD_OP_XOR:
      begin
        res_o = wval_i ^ fval_i;
        upd_z_o = 1'b1;
      end
      `BOD_OP_MOV:
      begin
        res_o = fval_i;
        upd_z_o = 1'b1;
      end
      `BOD_OP_INC:
      begin
        res_o = fval_i + 8'h01;
        upd_z_o = 1'b1;
      end
      `BOD_OP_INCSZ:
      begin
        res_o = fval_i + 8'h01;
        skip_o = (res_o == 8'h00);
      end
      `BOD_OP_DECSZ:
      begin
        res_o = fval_i - 8'h01;
        skip_o = (res_o == 8'h00);
      end
      `BOD_OP_RLC:
      begin
        res_o = {fval_i[6:0], c_i};
        c_o = fval_i[7];
        upd_c_o = 1'b1;
      end
      `BOD_OP_RRC:
      begin
        res_o = {c_i, fval_i[7:1]};
        c_o = fval_i[0];
        upd_c_o = 1'b1;
      end
      `BOD_OP_SWAP:
        res_o = {fval_i[3:0], fval_i[7:4]};
      default:
      begin
        has_res_o = 1'b0;
        known_o = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

// ---- hdl/bod_ahb_slave.v ----
`timescale 1ns/1ns
`default_nettype none
`include "bod_regs.vh"
module bod_ahb_slave (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  // AHB-Lite
  input  wire        hsel_i,
  input  wire [11:0] haddr_i,
  input  wire [1:0]  htrans_i,
  input  wire        hwrite_i,
  input  wire        hready_i,
  input  wire [31:0] hwdata_i,
  output reg  [31:0] hrdata_o,
  output wire        hreadyout_o,
  // Register side
  output wire [11:0] rd_addr_o,
  input  wire [31:0] rd_data_i,
  output wire        wr_en_o,
  output reg  [11:0] wr_addr_o,
  output wire [31:0] wr_data_o
);
  reg  wr_pend;
  wire take;

  assign take = ce_i & hsel_i & htrans_i[1] & hready_i;
  assign rd_addr_o = {haddr_i[11:2], 2'h0};
  assign wr_en_o = wr_pend & ce_i;
  assign wr_data_o = hwdata_i;
  assign hreadyout_o = ce_i;

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_pend <= 1'b0;
      wr_addr_o <= 12'h000;
      hrdata_o <= 32'h00000000;
    end
    else if (ce_i)
    begin
      wr_pend <= take & hwrite_i;
      if (take)
        wr_addr_o <= {haddr_i[11:2], 2'h0};
      if (take & ~hwrite_i)
        hrdata_o <= rd_data_i;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/bod_core.v ----
// What this block does
// - Every instruction is taken as a single 14-bit word of opcode plus operand fields.
// - The 7-bit file field picks one of the file registers 0x00 to 0x7F.
// - Destination bit 0 sends the result to the working register, 1 back to the file register.
// - The bit-select field names one bit position inside an 8-bit file register.
// - Don't-care bits never change the decoded operation.
// - One instruction cycle each, two when a skip is taken, the second acting as a no-op.
// - One instruction cycle is four consecutive clock periods.
// - Nibble 0100 ORs the working register with the file register and updates only zero.
// - Nibble 1011 decrements, routes by destination, skips on a zero result, no flags.
// - Nibble 1111 increments, routes by destination, skips on a zero result, no flags.
// - Nibble 1101 rotates left through carry and changes only carry.
// - Nibble 1100 rotates right through carry and changes only carry.
`timescale 1ns/1ns
`default_nettype none
`include "bod_regs.vh"
module bod_core (
  // Clock, reset, enable
  input  wire        CLOCK_I,
  input  wire        RST_I,
  input  wire        CE_I,
  // AHB-Lite slave
  input  wire        HSEL_I,
  input  wire [31:0] HADDR_I,
  input  wire [1:0]  HTRANS_I,
  input  wire        HWRITE_I,
  input  wire [2:0]  HSIZE_I,
  input  wire        HREADY_I,
  input  wire [31:0] HWDATA_I,
  output wire [31:0] HRDATA_O,
  output wire        HREADYOUT_O,
  output wire        HRESP_O,
  // Program memory
  output wire [12:0] PROG_ADDR_O,
  input  wire [13:0] PROG_DATA_I,
  // Status
  output wire        RUNNING_O,
  output reg         CYCLE_END_O,
  output reg  [7:0]  BIT_MASK_O
);
  // Register file and core state
  reg  [7:0]  file_mem [0:127];
  reg  [7:0]  w;
  reg         c;
  reg         dc;
  reg         z;
  reg  [12:0] pc;
  reg  [13:0] instr;
  reg  [1:0]  phase;
  reg         flush;
  reg         skip_pend;
  reg         unsup;
  reg  [7:0]  opnd;
  reg  [7:0]  res;
  reg         res_wr;
  reg         res_c;
  reg         res_dc;
  reg         res_skip;
  reg         res_upd_c;
  reg         res_upd_dc;
  reg         res_upd_z;
  reg         res_known;
  reg         run;
  reg         step;
  reg  [6:0]  faddr;
  reg  [31:0] count;
  reg  [31:0] rd_data;
  // Bus side wires
  wire [11:0] rd_addr;
  wire        wr_en;
  wire [11:0] wr_addr;
  wire [31:0] wr_data;
  // Decode wires
  wire        byte_class;
  wire [3:0]  op;
  wire        dest;
  wire [6:0]  fsel;
  wire [2:0]  bsel;
  wire        active;
  wire        commit;
  wire        executes;
  // ALU wires
  wire [7:0]  alu_res;
  wire        alu_has;
  wire        alu_c;
  wire        alu_dc;
  wire        alu_upd_c;
  wire        alu_upd_dc;
  wire        alu_upd_z;
  wire        alu_skip;
  wire        alu_known;
  integer     i;

  // One-hot mask of a bit position in a file register
  function [7:0] bit_mask;
    input [2:0] pos;
    begin
      bit_mask = 8'h01 << pos;
    end
  endfunction

  // Field split of the fetched word
  assign byte_class = (instr[`BOD_CLASS_HI:`BOD_CLASS_LO] == `BOD_CLASS_BYTE);
  assign op = instr[`BOD_OP_HI:`BOD_OP_LO];
  assign dest = instr[`BOD_DEST_BIT];
  assign fsel = instr[`BOD_FILE_HI:0];
  assign bsel = instr[`BOD_BIT_HI:`BOD_BIT_LO];

  // Sequencing
  assign active = CE_I & (run | step | (phase != `BOD_PH_FETCH));
  assign commit = active & (phase == `BOD_PH_WRITE);
  assign executes = commit & ~flush & byte_class;
  assign PROG_ADDR_O = pc;
  assign RUNNING_O = run | step | (phase != `BOD_PH_FETCH);
  assign HRESP_O = 1'b0;

  bod_alu u_alu (
    .op_i      (op),
    .dest_i    (dest),
    .fval_i    (opnd),
    .wval_i    (w),
    .c_i       (c),
    .res_o     (alu_res),
    .has_res_o (alu_has),
    .c_o       (alu_c),
    .dc_o      (alu_dc),
    .upd_c_o   (alu_upd_c),
    .upd_dc_o  (alu_upd_dc),
    .upd_z_o   (alu_upd_z),
    .skip_o    (alu_skip),
    .known_o   (alu_known)
  );

  bod_ahb_slave u_bus (
    .clk_i       (CLOCK_I),
    .rst_i       (RST_I),
    .ce_i        (CE_I),
    .hsel_i      (HSEL_I),
    .haddr_i     (HADDR_I[11:0]),
    .htrans_i    (HTRANS_I),
    .hwrite_i    (HWRITE_I),
    .hready_i    (HREADY_I),
    .hwdata_i    (HWDATA_I),
    .hrdata_o    (HRDATA_O),
    .hreadyout_o (HREADYOUT_O),
    .rd_addr_o   (rd_addr),
    .rd_data_i   (rd_data),
    .wr_en_o     (wr_en),
    .wr_addr_o   (wr_addr),
    .wr_data_o   (wr_data)
  );

  // Register read mux
  always @*
  begin
    rd_data = 32'h00000000;
    case (rd_addr)
      `BOD_CTRL_OFS:
        rd_data = {30'h00000000, step, run};
      `BOD_STAT_OFS:
        rd_data = {19'h00000, unsup, skip_pend, z, dc, c, w};
      `BOD_PC_OFS:
        rd_data = {19'h00000, pc};
      `BOD_FADDR_OFS:
        rd_data = {25'h0000000, faddr};
      `BOD_FDATA_OFS:
        rd_data = {24'h000000, file_mem[faddr]};
      `BOD_INSTR_OFS:
        rd_data = {18'h00000, instr};
      `BOD_COUNT_OFS:
        rd_data = count;
      default:
        rd_data = 32'h00000000;
    endcase
  end

  // Instruction cycle: fetch, read, execute, write back
  always @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      phase <= `BOD_PH_FETCH;
      instr <= `BOD_INSTR_RST;
      flush <= 1'b0;
      opnd <= 8'h00;
      res <= 8'h00;
      res_wr <= 1'b0;
      res_c <= 1'b0;
      res_dc <= 1'b0;
      res_skip <= 1'b0;
      res_upd_c <= 1'b0;
      res_upd_dc <= 1'b0;
      res_upd_z <= 1'b0;
      res_known <= 1'b0;
      CYCLE_END_O <= 1'b0;
      BIT_MASK_O <= 8'h00;
    end
    else if (CE_I)
    begin
      CYCLE_END_O <= commit;
      if (active)
      begin
        if (phase == `BOD_PHASES)
          phase <= `BOD_PH_FETCH;
        else
          phase <= phase + 2'h1;
        case (phase)
          `BOD_PH_FETCH:
          begin
            instr <= PROG_DATA_I;
            flush <= skip_pend;
          end
          `BOD_PH_READ:
          begin
            opnd <= file_mem[fsel];
            BIT_MASK_O <= bit_mask(bsel);
          end
          `BOD_PH_EXEC:
          begin
            res <= alu_res;
            res_wr <= alu_has;
            res_c <= alu_c;
            res_dc <= alu_dc;
            res_skip <= alu_skip;
            res_upd_c <= alu_upd_c;
            res_upd_dc <= alu_upd_dc;
            res_upd_z <= alu_upd_z;
            res_known <= alu_known;
          end
          default:
            flush <= 1'b0;
        endcase
      end
    end
  end

  // Architectural state and register writes
  always @(posedge CLOCK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      w <= `BOD_W_RST;
      c <= 1'b0;
      dc <= 1'b0;
      z <= 1'b0;
      pc <= `BOD_PC_RST;
      skip_pend <= 1'b0;
      unsup <= 1'b0;
      run <= 1'b0;
      step <= 1'b0;
      faddr <= 7'h00;
      count <= 32'h00000000;
    end
    else if (CE_I)
    begin
      // Software writes; W, flag, skip and PC writes apply only while halted
      if (wr_en)
      begin
        case (wr_addr)
          `BOD_CTRL_OFS:
          begin
            run <= wr_data[`BOD_CTRL_RUN];
            step <= wr_data[`BOD_CTRL_STEP];
          end
          `BOD_STAT_OFS:
          begin
            if (wr_data[`BOD_STAT_UNSUP])
              unsup <= 1'b0;
            if (~RUNNING_O)
            begin
              w <= wr_data[`BOD_STAT_W_HI:0];
              c <= wr_data[`BOD_STAT_C];
              dc <= wr_data[`BOD_STAT_DC];
              z <= wr_data[`BOD_STAT_Z];
              skip_pend <= wr_data[`BOD_STAT_SKIP];
            end
          end
          `BOD_PC_OFS:
            if (~RUNNING_O)
              pc <= wr_data[12:0];
          `BOD_FADDR_OFS:
            faddr <= wr_data[6:0];
          `BOD_COUNT_OFS:
            count <= wr_data;
          default:
            faddr <= faddr;
        endcase
      end
      // Instruction retire
      if (commit)
      begin
        pc <= pc + 13'h0001;
        count <= count + 32'h00000001;
        step <= 1'b0;
        skip_pend <= 1'b0;
        if (~flush & (~byte_class | ~res_known))
          unsup <= 1'b1;
        if (executes)
        begin
          if (res_wr & ~dest)
            w <= res;
          if (res_upd_c)
            c <= res_c;
          if (res_upd_dc)
            dc <= res_dc;
          if (res_upd_z)
            z <= (res == 8'h00);
          skip_pend <= res_skip;
        end
      end
    end
  end

  // File register writes: core write-back, else bus window while halted
  always @(posedge CLOCK_I)
  begin
    if (CE_I)
    begin
      if (executes & res_wr & dest)
        file_mem[fsel] <= res;
      else if (wr_en & (wr_addr == `BOD_FDATA_OFS) & ~RUNNING_O)
        file_mem[faddr] <= wr_data[7:0];
    end
  end

  // Power-up contents are defined as zero for simulation and synthesis
  initial
  begin
    for (i = 0; i < 128; i = i + 1)
      file_mem[i] = 8'h00;
  end
endmodule
`default_nettype wire

// ---- verification/bod_core_checker.sv ----
`timescale 1ns/1ns
`default_nettype none
module bod_core_checker (
  // Clock and reset
  input wire logic        CLOCK_I,
  input wire logic        RST_I,
  // Bus
  input wire logic        CE_I,
  input wire logic        HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0]  HTRANS_I,
  input wire logic        HWRITE_I,
  input wire logic        HREADY_I,
  input wire logic [31:0] HRDATA_O,
  // Core
  input wire logic [12:0] PROG_ADDR_O,
  input wire logic [13:0] PROG_DATA_I,
  input wire logic        RUNNING_O,
  input wire logic        CYCLE_END_O,
  input wire logic [7:0]  BIT_MASK_O
);
  wire       rd_take;
  wire [2:0] bit_field;
  assign rd_take   = CE_I && HSEL_I && HTRANS_I[1] && HREADY_I && !HWRITE_I;
  assign bit_field = PROG_DATA_I[9:7];
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  chk_cycle_gap: assert property (CYCLE_END_O |=> !CYCLE_END_O [*3])
    else $error("instruction cycles closer than four clocks");
  chk_step_length: assert property (
    $rose(RUNNING_O) |-> !CYCLE_END_O [*4] ##[1:4] CYCLE_END_O)
    else $error("instruction cycle not four clocks long");
  chk_pc_advance: assert property (
    CYCLE_END_O |-> PROG_ADDR_O == $past(PROG_ADDR_O) + 13'h0001)
    else $error("program counter not advanced by one");
  chk_pc_stable: assert property (
    $changed(PROG_ADDR_O) && $past(RUNNING_O) |-> CYCLE_END_O)
    else $error("program counter moved inside an instruction cycle");
  chk_mask_field: assert property (
    CYCLE_END_O |-> BIT_MASK_O == (8'h01 << $past(bit_field, 2)))
    else $error("bit mask does not match bit field");
  chk_mask_onehot: assert property ($onehot0(BIT_MASK_O))
    else $error("bit mask selects more than one bit");
  chk_faddr_width: assert property (
    rd_take && HADDR_I[11:0] == 12'h00C |=> HRDATA_O[31:7] == 25'h0000000)
    else $error("file address wider than seven bits");
  chk_word_width: assert property (
    rd_take && HADDR_I[11:0] == 12'h014 |=> HRDATA_O[31:14] == 18'h00000)
    else $error("instruction word wider than fourteen bits");
endmodule
bind bod_core bod_core_checker bod_core_checker_i (
  .CLOCK_I(CLOCK_I), .RST_I(RST_I), .CE_I(CE_I), .HSEL_I(HSEL_I), .HADDR_I(HADDR_I),
  .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HREADY_I(HREADY_I), .HRDATA_O(HRDATA_O),
  .PROG_ADDR_O(PROG_ADDR_O), .PROG_DATA_I(PROG_DATA_I), .RUNNING_O(RUNNING_O),
  .CYCLE_END_O(CYCLE_END_O), .BIT_MASK_O(BIT_MASK_O));
`default_nettype wire

// ---- verification/bod_prog_mem.sv ----
`timescale 1ns/1ns
`default_nettype none
module bod_prog_mem (
  // Fetch port
  input  wire logic [12:0] prog_addr_i,
  output wire logic [13:0] prog_data_o
);
  logic [13:0] mem [0:15];
  // Whole word per address; beyond the table a no-op word
  assign prog_data_o = (prog_addr_i < 13'h0010) ? mem[prog_addr_i[3:0]] : 14'h0000;
endmodule
`default_nettype wire

// ---- verification/byte_op_instruction_decoder_test.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "bod_regs.vh"
module byte_op_instruction_decoder_test;
  logic        clock;
  logic        rst;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  wire  [31:0] hrdata;
  wire         hready;
  wire  [12:0] prog_addr;
  wire  [13:0] prog_data;
  wire  [7:0]  bit_mask;
  wire         cycle_end;
  wire         running;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  bod_core bod_core_i (
    .CLOCK_I(clock), .RST_I(rst), .CE_I(1'b1), .HSEL_I(1'b1), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HREADY_I(hready),
    .HWDATA_I(hwdata), .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(),
    .PROG_ADDR_O(prog_addr), .PROG_DATA_I(prog_data), .RUNNING_O(running),
    .CYCLE_END_O(cycle_end), .BIT_MASK_O(bit_mask));

  bod_prog_mem bod_prog_mem_i (.prog_addr_i(prog_addr), .prog_data_o(prog_data));

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic end_of_test;
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_mismatch = n_mismatch + 1;
      end_of_test();
    end
  end

  task automatic compare(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Single word transfer, entered and left just after a rising edge
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    haddr  <= {20'h00000, a};
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    q = hrdata;
  endtask

  task automatic rd_check(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h00000000, q);
    compare(q, exp);
  endtask

  task automatic step;
    logic [31:0] q;
    int          k;
    bus(1'b1, `BOD_CTRL_OFS, 32'h00000002, q);
    k = 0;
    while (cycle_end !== 1'b1 && k < 40)
    begin
      @(negedge clock);
      k++;
    end
    compare({31'h00000000, cycle_end}, 32'h00000001);
    @(posedge clock);
    @(posedge clock);
  endtask

  // One word at address 0, a clear-accumulator word behind it to expose a missed skip
  task automatic do_op(input logic [13:0] w, input logic [7:0] fv, input logic [7:0] wv,
                       input logic c, input logic [12:0] es, input logic [7:0] ef);
    logic [31:0] q;
    bod_prog_mem_i.mem[0] <= w;
    bod_prog_mem_i.mem[1] <= 14'h0100;
    bus(1'b1, `BOD_FADDR_OFS, {25'h0000000, w[6:0]}, q);
    bus(1'b1, `BOD_FDATA_OFS, {24'h000000, fv}, q);
    bus(1'b1, `BOD_STAT_OFS, {19'h00000, 1'b1, 3'h0, c, wv}, q);
    bus(1'b1, `BOD_PC_OFS, 32'h00000000, q);
    step();
    rd_check(`BOD_STAT_OFS, {19'h00000, es});
    rd_check(`BOD_FDATA_OFS, {24'h000000, ef});
    rd_check(`BOD_PC_OFS, 32'h00000001);
    rd_check(`BOD_INSTR_OFS, {18'h00000, w});
    compare({24'h000000, bit_mask}, {24'h000000, 8'h01 << w[9:7]});
    if (es[11])
    begin
      step();
      rd_check(`BOD_STAT_OFS, {19'h00000, es & 13'h17FF});
      rd_check(`BOD_PC_OFS, 32'h00000002);
    end
    $display("word %h done", w);
  endtask

  initial
  begin
    logic [31:0] q;
    int          n_end;
    int          k;
    rst = 1'b1;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h00000000;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd_check(`BOD_PC_OFS, 32'h00000000);
    rd_check(`BOD_STAT_OFS, 32'h00000000);
    bus(1'b1, `BOD_FADDR_OFS, 32'h000000FF, q);
    rd_check(`BOD_FADDR_OFS, 32'h0000007F);
    bus(1'b1, 12'h01C, 32'hFFFFFFFF, q);
    rd_check(12'h01C, 32'h00000000);
    $display("register checks done");
    do_op(14'h04FF, 8'h00, 8'h00, 1'b1, 13'h0500, 8'h00);
    do_op(14'h0410, 8'h0F, 8'hF0, 1'b0, 13'h00FF, 8'h0F);
    do_op(14'h0BA0, 8'h01, 8'h33, 1'b1, 13'h0933, 8'h00);
    do_op(14'h0B21, 8'h05, 8'h00, 1'b0, 13'h0004, 8'h05);
    do_op(14'h0F80, 8'hFF, 8'h11, 1'b0, 13'h0811, 8'h00);
    do_op(14'h0F01, 8'h7F, 8'h00, 1'b0, 13'h0080, 8'h7F);
    do_op(14'h0DB0, 8'h81, 8'h00, 1'b0, 13'h0100, 8'h02);
    do_op(14'h0D31, 8'h80, 8'h00, 1'b0, 13'h0100, 8'h80);
    do_op(14'h0CC0, 8'h01, 8'h00, 1'b1, 13'h0100, 8'h80);
    do_op(14'h0C41, 8'h02, 8'h55, 1'b1, 13'h0081, 8'h02);
    do_op(14'h0750, 8'h08, 8'h08, 1'b0, 13'h0210, 8'h08);
    do_op(14'h02D1, 8'h05, 8'h05, 1'b0, 13'h0705, 8'h00);
    do_op(14'h0552, 8'hF0, 8'h0F, 1'b0, 13'h0400, 8'hF0);
    do_op(14'h0853, 8'h3C, 8'h00, 1'b0, 13'h003C, 8'h3C);
    do_op(14'h0AD4, 8'hFF, 8'h01, 1'b0, 13'h0401, 8'h00);
    do_op(14'h0E55, 8'hA5, 8'h00, 1'b0, 13'h005A, 8'hA5);
    do_op(14'h01E0, 8'h77, 8'h22, 1'b0, 13'h0422, 8'h00);
    do_op(14'h017F, 8'h77, 8'h22, 1'b0, 13'h0400, 8'h77);
    do_op(14'h00E1, 8'h00, 8'h9C, 1'b0, 13'h009C, 8'h9C);
    do_op(14'h0060, 8'h11, 8'h9C, 1'b0, 13'h009C, 8'h11);
    do_op(14'h06D5, 8'h5A, 8'h5A, 1'b1, 13'h055A, 8'h00);
    do_op(14'h0380, 8'h12, 8'h34, 1'b1, 13'h1134, 8'h12);
    do_op(14'h1480, 8'h3C, 8'h00, 1'b0, 13'h1000, 8'h3C);
    // Free run of three words and a no-op, halted while the fourth is in flight
    for (int j = 0; j < 16; j++)
      bod_prog_mem_i.mem[j] <= 14'h0000;
    bod_prog_mem_i.mem[0] <= 14'h0AA0;
    bod_prog_mem_i.mem[1] <= 14'h0820;
    bod_prog_mem_i.mem[2] <= 14'h0FA0;
    bus(1'b1, `BOD_FADDR_OFS, 32'h00000020, q);
    bus(1'b1, `BOD_FDATA_OFS, 32'h00000003, q);
    bus(1'b1, `BOD_STAT_OFS, 32'h00001000, q);
    bus(1'b1, `BOD_PC_OFS, 32'h00000000, q);
    bus(1'b1, `BOD_COUNT_OFS, 32'h00000000, q);
    bus(1'b1, `BOD_CTRL_OFS, 32'h00000001, q);
    n_end = 0;
    k = 0;
    while (n_end < 3 && k < 100)
    begin
      @(negedge clock);
      if (cycle_end === 1'b1)
        n_end++;
      k++;
    end
    compare(n_end, 3);
    @(posedge clock);
    bus(1'b1, `BOD_CTRL_OFS, 32'h00000000, q);
    rd_check(`BOD_STAT_OFS, 32'h00000004);
    rd_check(`BOD_FDATA_OFS, 32'h00000005);
    rd_check(`BOD_PC_OFS, 32'h00000004);
    rd_check(`BOD_COUNT_OFS, 32'h00000004);
    @(negedge clock);
    compare({31'h00000000, running}, 32'h00000000);
    $display("run test done");
    end_of_test();
  end
endmodule
`default_nettype wire
